//--- core/timer16_map.svh
// timer16_map: offsets, field positions, reset values and counts
// assumes: included by both ends of the timer byte bus
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH

// byte locations on the timer bus
`define A_CNT_LO  4'h0
`define A_CNT_HI  4'h1
`define A_CMPA_LO 4'h2
`define A_CAP_LO  4'h8
`define A_CAP_HI  4'h9
`define A_CTRL_A  4'ha
`define A_CTRL_B  4'hb
`define A_FLAGS   4'hc
`define A_MASK    4'hd
`define NUM_CMP   3

// control and flag fields
`define CA_WGM_LSB 0
`define CB_CS_LSB  0
`define CB_WGM_LSB 3
`define FL_OVF     0
`define MK_OVF     0

// clock-select codes
`define CS_STOP  3'h0
`define CS_DIV1  3'h1
`define CS_DIV8  3'h2
`define CS_DIV64 3'h3
`define CS_D256  3'h4
`define CS_D1024 3'h5
`define CS_EXTF  3'h6
`define CS_EXTR  3'h7

// prescaler taps, as powers of two
`define PS_W     10
`define PS_B8    3
`define PS_B64   6
`define PS_B256  8
`define PS_B1024 10

// count limits and reset values
`define TOP_MAX  16'hffff
`define TOP_8    16'h00ff
`define TOP_9    16'h01ff
`define TOP_10   16'h03ff
`define RST_WORD 16'h0000
`define RST_BYTE 8'h00

// controller registers on wishbone, byte addresses
`define H_CMD       4'h0
`define H_DATA      4'h4
`define H_STAT      4'h8
`define CMD_WRITE   8
`define CMD_LO_ONLY 9
`define SEL_WORDS   4'h5
`define SEL_LAST    4'h8
`define STAT_BUSY   0

`endif

//--- core/timer16_pkg.sv
// timer16_pkg: shared types of the timer and its controller
// assumes: compiled before both ends
package timer16_pkg;

	// counting sequence families
	typedef enum logic [1:0] {
		KIND_NORMAL,
		KIND_CTC,
		KIND_FAST,
		KIND_PHASE
	} count_kind_t;

	// controller access sequencer
	typedef enum logic [1:0] {
		S_IDLE,
		S_FIRST,
		S_SECOND,
		S_FETCH
	} seq_state_t;

endpackage

//--- core/timer16_bus_if.sv
// timer16_bus_if: byte-wide register bus between controller and timer
// assumes: both ends on one clock; rdata valid the cycle after rd
`timescale 1ns/10ps

interface timer16_bus_if;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rd;
	logic       wr;

	modport dev  (input addr, input wdata, input rd, input wr,
		output rdata);
	modport host (output addr, output wdata, output rd, output wr,
		input rdata);
endinterface

//--- core/timer16_dev.sv
// timer16_dev: 16-bit up/down timer counter behind a byte register bus
// assumes: single system clock, controller on timer16_bus_if, pins async
//
// Function
// R1 - each 16-bit register is two byte locations
// R2 - one high-byte latch shared per timer
// R3 - low write loads byte plus latch together
// R4 - low read copies high byte into latch
// R5 - compare reads bypass the shared latch
// R6 - writer sends high byte before low byte
// R7 - reader takes low byte before high byte
// R8 - no other access between the two bytes
// R9 - one high write may serve several lows
// R10 - counter high location is the latch itself
// R11 - three-bit clock select picks tick source
// R12 - select zero stops ticks, count holds
// R13 - counter clears, increments or decrements per tick
// R14 - count, direction, clear in; top, bottom out
// R15 - counter accessible whether ticking or not
// R16 - bus write beats any count operation
// R17 - mode field split over control registers
// R18 - overflow flag set per mode, raises request
// R19 - bottom 0x0000, max 0xffff, fixed tops
// R20 - reset zeroes counter, latch, clock select
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`include "timer16_map.svh"

module timer16_dev
	import timer16_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// byte register bus
	timer16_bus_if.dev            bus,
	// external pins
	input  wire logic             ext_clk_pin_i,
	input  wire logic             capture_pin_i,
	// counter state and request
	output logic [CNT_W-1:0]      count_value_o,
	output logic                  top_o,
	output logic                  bottom_o,
	output logic                  overflow_irq_o
);

	// the byte access scheme only serves a 16-bit counter
	if (CNT_W != 16) begin : g_chk
		$error("timer16_dev: CNT_W must be 16");
	end

	logic [CNT_W-1:0]  cnt_q;
	logic [CNT_W-1:0]  cnt_d;
	logic [CNT_W-1:0]  cmp_q [`NUM_CMP];
	logic [CNT_W-1:0]  cap_q;
	logic [CNT_W-1:0]  top_val;
	logic [7:0]        latch_q;
	logic [7:0]        ctrl_a_q;
	logic [7:0]        ctrl_b_q;
	logic [7:0]        mask_q;
	logic [7:0]        rdata_q;
	logic [7:0]        rd_val;
	logic [`PS_W-1:0]  pre_q;
	logic [3:0]        wgm;
	logic [2:0]        cs;
	count_kind_t       kind;
	logic              dir_down_q;
	logic              dir_d;
	logic              ovf_q;
	logic              ovf_evt;
	logic              tick;
	logic              ext_s1_q;
	logic              ext_s2_q;
	logic              ext_s3_q;
	logic              cap_s1_q;
	logic              cap_s2_q;
	logic              cap_s3_q;
	logic              wr_cnt_lo;
	logic              wr_hi;
	logic              at_top;
	logic              at_bot;
	logic              at_max;

	// bus strobes
	assign wr_cnt_lo = bus.wr && (bus.addr == `A_CNT_LO);
	assign wr_hi     = bus.wr && bus.addr[0] && (bus.addr <= `A_CAP_HI);

	// shared high-byte latch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_q <= `RST_BYTE;                             // [R20]
		end else if (wr_hi) begin
			latch_q <= bus.wdata;                         // [R2] [R10]
		end else if (bus.rd && bus.addr == `A_CNT_LO) begin
			latch_q <= cnt_q[15:8];                       // [R4] [R10]
		end else if (bus.rd && bus.addr == `A_CAP_LO) begin
			latch_q <= cap_q[15:8];                            // [R4]
		end
	end

	// read data selection, byte locations
	always_comb begin
		rd_val = `RST_BYTE;
		if (bus.addr == `A_CNT_LO) begin
			rd_val = cnt_q[7:0];                               // [R1]
		end else if (bus.addr == `A_CNT_HI) begin
			rd_val = latch_q;                                 // [R10]
		end else if (bus.addr == `A_CMPA_LO) begin
			rd_val = cmp_q[0][7:0];
		end else if (bus.addr == 4'h3) begin
			rd_val = cmp_q[0][15:8];                           // [R5]
		end else if (bus.addr == 4'h4) begin
			rd_val = cmp_q[1][7:0];
		end else if (bus.addr == 4'h5) begin
			rd_val = cmp_q[1][15:8];                           // [R5]
		end else if (bus.addr == 4'h6) begin
			rd_val = cmp_q[2][7:0];
		end else if (bus.addr == 4'h7) begin
			rd_val = cmp_q[2][15:8];                           // [R5]
		end else if (bus.addr == `A_CAP_LO) begin
			rd_val = cap_q[7:0];
		end else if (bus.addr == `A_CAP_HI) begin
			rd_val = latch_q;
		end else if (bus.addr == `A_CTRL_A) begin
			rd_val = ctrl_a_q;
		end else if (bus.addr == `A_CTRL_B) begin
			rd_val = ctrl_b_q;
		end else if (bus.addr == `A_FLAGS) begin
			rd_val = {7'h00, ovf_q};
		end else if (bus.addr == `A_MASK) begin
			rd_val = mask_q;
		end
	end

	// registered read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= `RST_BYTE;
		end else if (bus.rd) begin
			rdata_q <= rd_val;
		end
	end
	assign bus.rdata = rdata_q;

	// compare values, one per channel
	for (genvar gi = 0; gi < `NUM_CMP; gi++) begin : g_cmp
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cmp_q[gi] <= `RST_WORD;
			end else if (bus.wr &&
				bus.addr == 4'(`A_CMPA_LO + 2 * gi)) begin
				cmp_q[gi] <= {latch_q, bus.wdata};            // [R3]
			end
		end
	end

	// control and mask registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_a_q <= `RST_BYTE;
			ctrl_b_q <= `RST_BYTE;                            // [R20]
			mask_q   <= `RST_BYTE;
		end else if (bus.wr && bus.addr == `A_CTRL_A) begin
			ctrl_a_q <= bus.wdata;
		end else if (bus.wr && bus.addr == `A_CTRL_B) begin
			ctrl_b_q <= bus.wdata;
		end else if (bus.wr && bus.addr == `A_MASK) begin
			mask_q <= bus.wdata;
		end
	end

	// overflow flag: event wins over a write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovf_q <= 1'b0;
		end else if (ovf_evt && tick && !wr_cnt_lo) begin
			ovf_q <= 1'b1;                                    // [R18]
		end else if (bus.wr && bus.addr == `A_FLAGS &&
			bus.wdata[`FL_OVF]) begin
			ovf_q <= 1'b0;
		end
	end
	assign overflow_irq_o = ovf_q && mask_q[`MK_OVF];         // [R18]

	// free prescaler and pin synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_q    <= '0;
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			cap_s1_q <= 1'b0;
			cap_s2_q <= 1'b0;
			cap_s3_q <= 1'b0;
		end else begin
			pre_q    <= pre_q + 1'b1;
			ext_s1_q <= ext_clk_pin_i;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			cap_s1_q <= capture_pin_i;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
		end
	end

	// timer tick source selection
	assign cs = ctrl_b_q[`CB_CS_LSB +: 3];
	always_comb begin
		case (cs)                                             // [R11]
		`CS_STOP:  tick = 1'b0;                               // [R12]
		`CS_DIV1:  tick = 1'b1;
		`CS_DIV8:  tick = &pre_q[`PS_B8-1:0];
		`CS_DIV64: tick = &pre_q[`PS_B64-1:0];
		`CS_D256:  tick = &pre_q[`PS_B256-1:0];
		`CS_D1024: tick = &pre_q[`PS_B1024-1:0];
		`CS_EXTF:  tick = ext_s3_q && !ext_s2_q;
		default:   tick = ext_s2_q && !ext_s3_q;
		endcase
	end

	// waveform mode decode into sequence family and top
	assign wgm = {ctrl_b_q[`CB_WGM_LSB +: 2],
		ctrl_a_q[`CA_WGM_LSB +: 2]};                          // [R17]
	always_comb begin
		kind    = KIND_NORMAL;
		top_val = `TOP_MAX;                                   // [R19]
		case (wgm)
		4'h1: begin kind = KIND_PHASE; top_val = `TOP_8; end
		4'h2: begin kind = KIND_PHASE; top_val = `TOP_9; end
		4'h3: begin kind = KIND_PHASE; top_val = `TOP_10; end
		4'h4: begin kind = KIND_CTC; top_val = cmp_q[0]; end
		4'h5: begin kind = KIND_FAST; top_val = `TOP_8; end
		4'h6: begin kind = KIND_FAST; top_val = `TOP_9; end
		4'h7: begin kind = KIND_FAST; top_val = `TOP_10; end
		4'h8, 4'ha: begin kind = KIND_PHASE; top_val = cap_q; end
		4'h9, 4'hb: begin kind = KIND_PHASE; top_val = cmp_q[0]; end
		4'hc: begin kind = KIND_CTC; top_val = cap_q; end
		4'he: begin kind = KIND_FAST; top_val = cap_q; end
		4'hf: begin kind = KIND_FAST; top_val = cmp_q[0]; end
		default: begin kind = KIND_NORMAL; top_val = `TOP_MAX; end
		endcase
	end

	// top and bottom indications
	assign at_top   = (cnt_q == top_val);                     // [R14]
	assign at_bot   = (cnt_q == `RST_WORD);                   // [R19]
	assign at_max   = (cnt_q == `TOP_MAX);
	assign top_o    = at_top;
	assign bottom_o = at_bot;

	// next count: clear, increment or decrement per family
	always_comb begin
		cnt_d   = cnt_q + 16'h0001;                           // [R13]
		dir_d   = dir_down_q;
		ovf_evt = 1'b0;
		case (kind)
		KIND_NORMAL: begin
			ovf_evt = at_max;
		end
		KIND_CTC: begin
			if (at_top) begin
				cnt_d = `RST_WORD;
			end
			ovf_evt = at_max;
		end
		KIND_FAST: begin
			if (at_top) begin
				cnt_d = `RST_WORD;
			end
			ovf_evt = at_top;
		end
		default: begin
			if (dir_down_q && !at_bot) begin
				cnt_d = cnt_q - 16'h0001;
			end else if (dir_down_q) begin
				dir_d   = 1'b0;
				ovf_evt = 1'b1;
			end else if (at_top) begin
				dir_d = 1'b1;
				cnt_d = cnt_q - 16'h0001;
			end
		end
		endcase
	end

	// counter and direction; bus write has priority
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q      <= `RST_WORD;                          // [R20]
			dir_down_q <= 1'b0;
		end else if (wr_cnt_lo) begin
			cnt_q <= {latch_q, bus.wdata};       // [R3] [R15] [R16]
		end else if (tick) begin
			cnt_q      <= cnt_d;                              // [R13]
			dir_down_q <= dir_d;
		end
	end
	assign count_value_o = cnt_q;

	// capture value: pin rising edge or bus write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_q <= `RST_WORD;
		end else if (bus.wr && bus.addr == `A_CAP_LO) begin
			cap_q <= {latch_q, bus.wdata};                     // [R3]
		end else if (cap_s2_q && !cap_s3_q) begin
			cap_q <= cnt_q;
		end
	end

endmodule

//--- core/timer16_host.sv
// timer16_host: wishbone-driven controller doing split 16-bit accesses
// assumes: sole master of timer16_bus_if, classic wishbone from software
`timescale 1ns/10ps
`include "timer16_map.svh"

module timer16_host
	import timer16_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// byte register bus
	timer16_bus_if.host      bus
);

	seq_state_t  state_q;
	logic [3:0]  sel_q;
	logic        write_q;
	logic        two_q;
	logic [15:0] data_q;
	logic [3:0]  addr_q;
	logic [7:0]  wdata_q;
	logic        rd_q;
	logic        wr_q;
	logic        ack_q;
	logic        req;
	logic        start;
	logic [3:0]  new_sel;
	logic        new_wr;
	logic        new_lo;
	logic [3:0]  base;

	// wishbone request taken on the first edge it is seen
	assign req     = wb_cyc_i && wb_stb_i && !ack_q;
	assign new_sel = wb_dat_i[3:0];
	assign new_wr  = wb_dat_i[`CMD_WRITE];
	assign new_lo  = wb_dat_i[`CMD_LO_ONLY];
	// commands while busy are dropped to keep byte pairs unbroken
	assign start   = req && wb_we_i && wb_adr_i == `H_CMD &&
		wb_sel_i[0] && wb_sel_i[1] && state_q == S_IDLE &&
		new_sel <= `SEL_LAST;                                 // [R8]
	assign base    = (new_sel < `SEL_WORDS) ? {new_sel[2:0], 1'b0} :
		new_sel + 4'h5;

	// ack and read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q    <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req && !wb_we_i && wb_adr_i == `H_DATA) begin
				wb_dat_o <= {16'h0000, data_q};
			end else if (req && !wb_we_i && wb_adr_i == `H_STAT) begin
				wb_dat_o <= {31'h0, state_q != S_IDLE};
			end else if (req && !wb_we_i && wb_adr_i == `H_CMD) begin
				wb_dat_o <= {22'h0, two_q, write_q, 4'h0, sel_q};
			end else if (req) begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end
	assign wb_ack_o = ack_q;

	// command fields
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_q   <= 4'h0;
			write_q <= 1'b0;
			two_q   <= 1'b0;
		end else if (start) begin
			sel_q   <= new_sel;
			write_q <= new_wr;
			two_q   <= new_sel < `SEL_WORDS && !(new_wr && new_lo);
		end
	end

	// data word: software writes when idle, reads land here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_q <= 16'h0000;
		end else if (state_q == S_SECOND && !write_q) begin
			data_q[7:0] <= bus.rdata;                          // [R7]
		end else if (state_q == S_FETCH && two_q) begin
			data_q[15:8] <= bus.rdata;
		end else if (state_q == S_FETCH) begin
			data_q <= {8'h00, bus.rdata};
		end else if (req && wb_we_i && wb_adr_i == `H_DATA &&
			state_q == S_IDLE) begin
			if (wb_sel_i[0]) begin
				data_q[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				data_q[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// byte access sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= S_IDLE;
			addr_q  <= 4'h0;
			wdata_q <= 8'h00;
			rd_q    <= 1'b0;
			wr_q    <= 1'b0;
		end else begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			case (state_q)
			S_IDLE: begin
				if (start && new_wr && new_sel < `SEL_WORDS && !new_lo) begin
					addr_q  <= base + 4'h1;                   // [R6]
					wdata_q <= data_q[15:8];
					wr_q    <= 1'b1;
					state_q <= S_FIRST;
				end else if (start) begin
					addr_q  <= base;             // [R7] [R9]
					wdata_q <= data_q[7:0];
					wr_q    <= new_wr;
					rd_q    <= !new_wr;
					state_q <= S_FIRST;
				end
			end
			S_FIRST: begin
				if (two_q) begin
					addr_q  <= addr_q ^ 4'h1;
					wdata_q <= data_q[7:0];
					wr_q    <= write_q;                       // [R6]
					rd_q    <= !write_q;                      // [R7]
					state_q <= S_SECOND;
				end else if (write_q) begin
					state_q <= S_IDLE;
				end else begin
					state_q <= S_FETCH;
				end
			end
			S_SECOND: begin
				state_q <= write_q ? S_IDLE : S_FETCH;
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end
	assign bus.addr  = addr_q;
	assign bus.wdata = wdata_q;
	assign bus.rd    = rd_q;
	assign bus.wr    = wr_q;

endmodule

//--- sim/timer16_monitor.sv
// timer16_monitor: concurrent checks on the timer byte bus and counter
// assumes: instantiated by the bench beside the bus, one clock domain
`timescale 1ns/10ps
`include "timer16_map.svh"

module timer16_monitor (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// byte bus
	input  wire logic [3:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic [7:0]  rdata,
	input  wire logic        rd,
	input  wire logic        wr,
	// counter outputs
	input  wire logic [15:0] count_value_o,
	input  wire logic        top_o,
	input  wire logic        bottom_o,
	input  wire logic        overflow_irq_o
);
	logic [2:0] cs_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// clock select as last written over the bus
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cs_q <= 3'h0;
		else if (wr && addr == `A_CTRL_B)
			cs_q <= wdata[2:0];
	end

	// split accesses to the counter
	sequence s_cnt_write;
		wr && addr == `A_CNT_HI ##1 wr && addr == `A_CNT_LO;
	endsequence
	sequence s_cnt_read;
		rd && addr == `A_CNT_LO ##1 rd && addr == `A_CNT_HI;
	endsequence

	a_reset_zero: assert property (
		$fell(rst_i) |-> count_value_o == `RST_WORD && bottom_o
			&& !top_o && !overflow_irq_o)
		else $error("counter not clear after reset");
	a_bottom_zero: assert property (
		bottom_o == (count_value_o == 16'h0000))
		else $error("bottom flag disagrees with count");
	a_stop_holds: assert property (
		cs_q == 3'h0 && $past(cs_q) == 3'h0 && $past(cs_q, 2) == 3'h0
			&& !$past(wr) && !$past(rst_i) |-> $stable(count_value_o))
		else $error("count moved while stopped");
	a_lo_write_load: assert property (
		s_cnt_write |=> count_value_o == {$past(wdata, 2), $past(wdata)})
		else $error("count not loaded by low write");
	a_lo_read_byte: assert property (
		rd && addr == `A_CNT_LO |=>
			{8'h00, rdata} == ($past(count_value_o) & 16'h00ff))
		else $error("low read byte wrong");
	a_hi_read_latch: assert property (
		s_cnt_read |=>
			{rdata, 8'h00} == ($past(count_value_o, 2) & 16'hff00))
		else $error("high read not from latched byte");
	a_hi_then_lo: assert property (
		wr && addr[0] && addr <= `A_CAP_HI |=>
			wr && addr == $past(addr) - 4'h1)
		else $error("high write not followed by low write");
	a_lo_then_hi: assert property (
		rd && !addr[0] && addr <= `A_CAP_LO |=>
			rd && addr == $past(addr) + 4'h1)
		else $error("low read not followed by high read");
	a_irq_cause: assert property (
		$rose(overflow_irq_o) |-> $past(top_o) || $past(bottom_o)
			|| $past(count_value_o) == `TOP_MAX || $past(wr))
		else $error("overflow request without cause");
	a_strobe_excl: assert property (
		!(rd && wr))
		else $error("read and write strobes together");
endmodule

//--- sim/timer16_byte_access_counter_tb.sv
// timer16_byte_access_counter_tb: wishbone-driven bench for both ends
// assumes: host and timer joined by timer16_bus_if on one clock
`timescale 1ns/10ps
`include "timer16_map.svh"

`define CHK(got, exp) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) begin \
			miscompares++; \
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
		end \
	end

module timer16_byte_access_counter_tb;
	import timer16_pkg::*;

	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [3:0]  wb_adr;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic        ext_pin;
	logic        cap_pin;
	logic [15:0] count_value;
	logic        top;
	logic        bottom;
	logic        irq;
	logic [31:0] rdat;
	int          n_checks;
	int          miscompares;
	int          cycles;

	timer16_bus_if timer16_bus_if_i ();

	timer16_host timer16_host_i (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.wb_cyc_i (wb_cyc),
		.wb_stb_i (wb_stb),
		.wb_we_i  (wb_we),
		.wb_adr_i (wb_adr),
		.wb_sel_i (4'hf),
		.wb_dat_i (wb_wdat),
		.wb_dat_o (wb_rdat),
		.wb_ack_o (wb_ack),
		.bus      (timer16_bus_if_i.host)
	);

	timer16_dev #(.CNT_W(16)) timer16_dev_i (
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.bus            (timer16_bus_if_i.dev),
		.ext_clk_pin_i  (ext_pin),
		.capture_pin_i  (cap_pin),
		.count_value_o  (count_value),
		.top_o          (top),
		.bottom_o       (bottom),
		.overflow_irq_o (irq)
	);

	timer16_monitor timer16_monitor_i (
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.addr           (timer16_bus_if_i.addr),
		.wdata          (timer16_bus_if_i.wdata),
		.rdata          (timer16_bus_if_i.rdata),
		.rd             (timer16_bus_if_i.rd),
		.wr             (timer16_bus_if_i.wr),
		.count_value_o  (count_value),
		.top_o          (top),
		.bottom_o       (bottom),
		.overflow_irq_o (irq)
	);

	// free-running system clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// watchdog on total run length
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one classic wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		do
			@(posedge clk_i);
		while (wb_ack !== 1'b1);
		rdat = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	// poll status until the controller is free
	task automatic idle();
		do
			wb(1'b0, `H_STAT, 32'h0);
		while (rdat[`STAT_BUSY] !== 1'b0);
	endtask

	// write a timer register, optionally low byte only
	task automatic put(input logic [3:0] s, input logic [15:0] v,
		input logic lo);
		wb(1'b1, `H_DATA, {16'h0000, v});
		wb(1'b1, `H_CMD, {22'h0, lo, 1'b1, 4'h0, s});
		idle();
	endtask

	// read a timer register into rdat
	task automatic get(input logic [3:0] s);
		wb(1'b1, `H_CMD, {28'h0, s});
		idle();
		wb(1'b0, `H_DATA, 32'h0);
	endtask

	task automatic t_reset();
		`CHK(count_value, `RST_WORD)
		`CHK(bottom, 1'b1)
		get(4'h0);
		`CHK(rdat[15:0], `RST_WORD)
		wb(1'b0, 4'hc, 32'h0);
		`CHK(rdat, 32'h0)
		$display("test reset done");
	endtask

	task automatic t_stopped();
		put(4'h0, 16'h01ff, 1'b0);
		`CHK(count_value, 16'h01ff)
		repeat (20) @(posedge clk_i);
		`CHK(count_value, 16'h01ff)
		get(4'h0);
		`CHK(rdat[15:0], 16'h01ff)
		$display("test stopped done");
	endtask

	task automatic t_latch();
		put(4'h1, 16'ha55a, 1'b0);
		put(4'h0, 16'h3344, 1'b0);
		get(4'h0);
		get(4'h1);
		`CHK(rdat[15:0], 16'ha55a)
		put(4'h3, 16'h0011, 1'b1);
		get(4'h3);
		`CHK(rdat[15:0], 16'h3311)
		get(4'h4);
		put(4'h2, 16'h0022, 1'b1);
		get(4'h2);
		`CHK(rdat[15:0], 16'h0022)
		$display("test latch done");
	endtask

	task automatic t_run();
		logic [15:0] c;
		put(4'h0, 16'hff00, 1'b0);
		put(4'h8, 16'h0001, 1'b0);
		put(4'h6, {13'h0, `CS_DIV1}, 1'b0);
		@(posedge clk_i);
		c = count_value;
		repeat (8) @(posedge clk_i);
		`CHK(count_value, c + 16'h0008)
		put(4'h0, 16'hfff0, 1'b0);
		repeat (300) begin
			@(posedge clk_i);
			if (irq === 1'b1)
				break;
		end
		`CHK(irq, 1'b1)
		put(4'h6, 16'h0000, 1'b0);
		put(4'h7, 16'h0001, 1'b0);
		`CHK(irq, 1'b0)
		$display("test run done");
	endtask

	task automatic t_down();
		int k;
		put(4'h0, 16'h00f0, 1'b0);
		put(4'h5, 16'h0001, 1'b0);
		put(4'h6, {13'h0, `CS_DIV1}, 1'b0);
		for (k = 0; k < 200 && top !== 1'b1; k++)
			@(posedge clk_i);
		repeat (5) @(posedge clk_i);
		`CHK(count_value, 16'h00fa)
		put(4'h6, 16'h0000, 1'b0);
		$display("test down done");
	endtask

	task automatic t_tops();
		logic [3:0]  md [4] = '{4'h0, 4'h5, 4'h6, 4'h7};
		logic [15:0] tp [4] = '{`TOP_MAX, `TOP_8, `TOP_9, `TOP_10};
		for (int i = 0; i < 4; i++) begin
			put(4'h5, {14'h0, md[i][1:0]}, 1'b0);
			put(4'h6, {11'h0, md[i][3:2], 3'h0}, 1'b0);
			put(4'h0, tp[i], 1'b0);
			`CHK(top, 1'b1)
			put(4'h0, tp[i] - 16'h0001, 1'b0);
			`CHK(top, 1'b0)
		end
		$display("test tops done");
	endtask

	// external rising-edge ticks, then a capture pin event
	task automatic t_ext();
		put(4'h5, 16'h0000, 1'b0);
		put(4'h0, 16'h0000, 1'b0);
		put(4'h6, {13'h0, `CS_EXTR}, 1'b0);
		repeat (3) begin
			@(posedge clk_i);
			ext_pin <= 1'b1;
			repeat (4) @(posedge clk_i);
			ext_pin <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
		`CHK(count_value, 16'h0003)
		put(4'h6, 16'h0000, 1'b0);
		@(posedge clk_i);
		cap_pin <= 1'b1;
		repeat (4) @(posedge clk_i);
		get(4'h4);
		`CHK(rdat[15:0], 16'h0003)
		$display("test ext done");
	endtask

	// reset, then the scenarios in turn
	initial begin
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 4'h0;
		wb_wdat = 32'h0;
		ext_pin = 1'b0;
		cap_pin = 1'b0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_stopped();
		t_latch();
		t_run();
		t_down();
		t_tops();
		t_ext();
		tally_and_finish();
	end
endmodule
